/* design/scf_pkg.sv */
package scf_pkg;

  // Clock and timing
  localparam int CLK_MHZ   = 100;
  localparam int REH_NS    = 1000;
  localparam int REH_CYC   = (REH_NS * CLK_MHZ + 999) / 1000;
  localparam int LPF_NS    = 100;
  localparam int LPF_CYC   = (LPF_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_W    = 8;
  localparam int LPF_W     = 4;
  localparam logic [HOLD_W-1:0] REH_LOAD = HOLD_W'(REH_CYC);
  localparam logic [LPF_W-1:0]  LPF_LAST = LPF_W'(LPF_CYC - 1);

  // Command codes
  localparam logic [7:0] REGISTER_PAGE_READ_CMD  = 8'hf0;
  localparam logic [7:0] CHANNEL_WRITE_CMD       = 8'h5a;
  localparam logic [7:0] CHANNEL_SAMPLE_READ_CMD = 8'h11;
  localparam logic [7:0] LATCH_CLEAR_CMD         = 8'h22;

  // Register page window
  localparam logic [15:0] PAGE_FIRST = 16'h0088;
  localparam logic [15:0] PAGE_LAST  = 16'h008f;

  // Constant bytes and counts
  localparam logic [7:0] PATTERN_AA   = 8'haa;
  localparam logic [7:0] FILL_FF      = 8'hff;
  localparam logic [5:0] BLOCK_LAST   = 6'h1f;
  localparam logic [15:0] CRC16_CLEAR = 16'h0000;
  localparam logic [7:0] CRC8_CLEAR   = 8'h00;

  // Reflected polynomials, shifted lsb first
  localparam logic [15:0] CRC16_POLY = 16'ha001;
  localparam logic [7:0]  CRC8_POLY  = 8'h8c;

  // Arbitrary identification body
  localparam logic [55:0] ROM_BODY = 56'h00_0000_0000_0129;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_CMD      = 4'b0001,
    ST_ADDR_LO  = 4'b0010,
    ST_ADDR_HI  = 4'b0011,
    ST_PAGE     = 4'b0100,
    ST_CAR      = 4'b0101,
    ST_CRC_LO   = 4'b0110,
    ST_CRC_HI   = 4'b0111,
    ST_FF_LOOP  = 4'b1000,
    ST_AA_LOOP  = 4'b1001,
    ST_CAW_NEW  = 4'b1010,
    ST_CAW_INV  = 4'b1011,
    ST_CAW_AA   = 4'b1100,
    ST_CAW_BACK = 4'b1101
  } scf_state_t;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC16_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC8_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rom_crc(input logic [55:0] body);
    logic [7:0] r;
    r = CRC8_CLEAR;
    for (int k = 0; k < 7; k++) begin
      r = crc8_byte(r, body[8*k +: 8]);
    end
    return r;
  endfunction

  localparam logic [63:0] ROM_CODE = {rom_crc(ROM_BODY), ROM_BODY};

endpackage

/* design/scf_framing.sv */
`timescale 1ns/1ps

// Operation
// [R1] Identification code carries its 8-bit checksum in the top byte, fixed.
// [R2] Master checks the checksum over the first 56 identification bits.
// [R3] Identification checksum uses x^8+x^5+x^4+1 on both ends.
// [R4] Identification checksum is sent true, not inverted.
// [R5] Sixteen-bit checksum uses x^16+x^15+x^2+1.
// [R6] Sixteen-bit checksum always goes out inverted.
// [R7] Page read covers command, both address bytes, data up to 008Fh.
// [R8] First sample block covers command code plus 32 samples, then inverted checksum.
// [R9] Later sample blocks restart the checksum over 32 samples only.
// [R10] Master rereads data whose checksum does not match.
// [R11] Each transaction starts with reset and presence, then selection and command.
// [R12] After address failure or page checksum, all further reads give FFh.
// [R13] Alternating loop answers every read with AAh until reset.
// [R14] Sample read repeats 32 samples plus inverted checksum while master reads.
// [R15] Channel write takes new state and its complement; applied only if complementary.
// [R16] Accepted write answers AAh then current pin state, then waits again.
// [R17] Non-complementary pair is invalid and leaves outputs unchanged.
// [R18] Low glitches are ignored during the rising-edge hold-off window.
// [R19] Low lasting past the hold-off window starts a new slot.
// [R20] Extra falling-edge filtering at standard speed, bypassed at overdrive.
// [R21] After an invalid write pair, all further reads give FFh.
// [R22] Latch clear always succeeds and enters the AAh loop.
// [R23] Channel write command code is 5Ah.
// [R24] Page read command is F0h with two address bytes, low first.
// [R25] Bytes enter checksum lsb first; inverted checksum sent low byte first.
module scf_framing (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        bus_in,
  input  wire logic        overdrive,
  output logic             slot_start,
  input  wire logic        bus_reset,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  input  wire logic [7:0]  pin_in,
  output logic [15:0]      page_addr,
  input  wire logic [7:0]  page_rdata,
  output logic [7:0]       chan_out,
  output logic             chan_write,
  output logic             latch_clear,
  output logic [63:0]      rom_code
);

  typedef struct packed {
    logic                            bus_s1;
    logic                            bus_s2;
    logic                            line_prev;
    logic [7:0]                      pin_s1;
    logic [7:0]                      pin_s2;
    logic [scf_pkg::HOLD_W-1:0]      hold_cnt;
    logic [scf_pkg::LPF_W-1:0]       low_cnt;
    logic                            slot;
    scf_pkg::scf_state_t             st;
    logic                            car_mode;
    logic [15:0]                     crc;
    logic [5:0]                      cnt;
    logic [15:0]                     addr;
    logic [7:0]                      first;
    logic [7:0]                      outs;
    logic                            wr;
    logic                            lclr;
    logic [1:0][7:0]                 bufd;
    logic                            rd;
    logic [1:0]                      count;
  } scf_regs_t;

  scf_regs_t  s;
  scf_regs_t  next_s;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic       can_push;
  logic       line;

  assign line       = s.bus_s2;
  assign can_push   = s.count != 2'd2;
  assign pop        = tx_ready && (s.count != 2'd0);
  assign tx_valid   = s.count != 2'd0;
  assign tx_data    = s.bufd[s.rd];
  assign slot_start = s.slot;
  assign page_addr  = s.addr;
  assign chan_out   = s.outs;
  assign chan_write = s.wr;
  assign latch_clear = s.lclr;
  assign rom_code   = scf_pkg::ROM_CODE; // [R1] [R3] [R4]

  always_comb begin
    next_s    = s;
    push      = 1'b0;
    push_data = scf_pkg::FILL_FF;

    // Input synchronisers
    next_s.bus_s1 = bus_in;
    next_s.bus_s2 = s.bus_s1;
    next_s.pin_s1 = pin_in;
    next_s.pin_s2 = s.pin_s1;

    // Glitch hold-off and slot start detection
    next_s.slot = 1'b0;
    if (s.hold_cnt != '0) begin
      next_s.hold_cnt = s.hold_cnt - 1'b1; // [R18]
      next_s.low_cnt  = '0;
    end else if (line) begin
      if (!s.line_prev) begin
        next_s.hold_cnt = scf_pkg::REH_LOAD; // [R18]
      end
      next_s.line_prev = 1'b1;
      next_s.low_cnt   = '0;
    end else if (s.line_prev) begin
      if (overdrive || s.low_cnt == scf_pkg::LPF_LAST) begin
        next_s.slot      = 1'b1; // [R19] [R20]
        next_s.line_prev = 1'b0;
        next_s.low_cnt   = '0;
      end else begin
        next_s.low_cnt = s.low_cnt + 1'b1; // [R20]
      end
    end

    // Command framing
    next_s.wr   = 1'b0;
    next_s.lclr = 1'b0;
    case (s.st)
      scf_pkg::ST_CMD: begin
        if (rx_valid) begin
          next_s.crc      = scf_pkg::crc16_byte(scf_pkg::CRC16_CLEAR, rx_data); // [R7] [R8] [R25]
          next_s.car_mode = 1'b0;
          next_s.cnt      = 6'h00;
          case (rx_data)
            scf_pkg::REGISTER_PAGE_READ_CMD: begin
              next_s.st = scf_pkg::ST_ADDR_LO; // [R24]
            end
            scf_pkg::CHANNEL_SAMPLE_READ_CMD: begin
              next_s.st       = scf_pkg::ST_CAR; // [R8]
              next_s.car_mode = 1'b1;
            end
            scf_pkg::CHANNEL_WRITE_CMD: begin
              next_s.st = scf_pkg::ST_CAW_NEW; // [R23]
            end
            scf_pkg::LATCH_CLEAR_CMD: begin
              next_s.st   = scf_pkg::ST_AA_LOOP; // [R22]
              next_s.lclr = 1'b1;
            end
            default: begin
              next_s.st = scf_pkg::ST_IDLE;
            end
          endcase
        end
      end
      scf_pkg::ST_ADDR_LO: begin
        if (rx_valid) begin
          next_s.addr[7:0] = rx_data; // [R24]
          next_s.crc       = scf_pkg::crc16_byte(s.crc, rx_data); // [R7]
          next_s.st        = scf_pkg::ST_ADDR_HI;
        end
      end
      scf_pkg::ST_ADDR_HI: begin
        if (rx_valid) begin
          next_s.addr[15:8] = rx_data;
          next_s.crc        = scf_pkg::crc16_byte(s.crc, rx_data); // [R7]
          if ({rx_data, s.addr[7:0]} >= scf_pkg::PAGE_FIRST && {rx_data, s.addr[7:0]} <= scf_pkg::PAGE_LAST) begin
            next_s.st = scf_pkg::ST_PAGE;
          end else begin
            next_s.st = scf_pkg::ST_FF_LOOP; // [R12]
          end
        end
      end
      scf_pkg::ST_PAGE: begin
        if (can_push) begin
          push       = 1'b1;
          push_data  = page_rdata;
          next_s.crc = scf_pkg::crc16_byte(s.crc, page_rdata); // [R7]
          if (s.addr == scf_pkg::PAGE_LAST) begin
            next_s.st = scf_pkg::ST_CRC_LO;
          end else begin
            next_s.addr = s.addr + 16'h0001;
          end
        end
      end
      scf_pkg::ST_CAR: begin
        if (can_push) begin
          push       = 1'b1;
          push_data  = s.pin_s2;
          next_s.crc = scf_pkg::crc16_byte(s.crc, s.pin_s2); // [R5] [R14]
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == scf_pkg::BLOCK_LAST) begin
            next_s.st = scf_pkg::ST_CRC_LO; // [R14]
          end
        end
      end
      scf_pkg::ST_CRC_LO: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = ~s.crc[7:0]; // [R6] [R25]
          next_s.st = scf_pkg::ST_CRC_HI;
        end
      end
      scf_pkg::ST_CRC_HI: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = ~s.crc[15:8]; // [R6]
          if (s.car_mode) begin
            next_s.crc = scf_pkg::CRC16_CLEAR; // [R9]
            next_s.cnt = 6'h00;
            next_s.st  = scf_pkg::ST_CAR;
          end else begin
            next_s.st = scf_pkg::ST_FF_LOOP; // [R12]
          end
        end
      end
      scf_pkg::ST_FF_LOOP: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = scf_pkg::FILL_FF; // [R12] [R21]
        end
      end
      scf_pkg::ST_AA_LOOP: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = scf_pkg::PATTERN_AA; // [R13]
        end
      end
      scf_pkg::ST_CAW_NEW: begin
        if (rx_valid) begin
          next_s.first = rx_data; // [R15]
          next_s.st    = scf_pkg::ST_CAW_INV;
        end
      end
      scf_pkg::ST_CAW_INV: begin
        if (rx_valid) begin
          if (rx_data == ~s.first) begin
            next_s.outs = s.first; // [R15]
            next_s.wr   = 1'b1;
            next_s.st   = scf_pkg::ST_CAW_AA;
          end else begin
            next_s.st = scf_pkg::ST_FF_LOOP; // [R17] [R21]
          end
        end
      end
      scf_pkg::ST_CAW_AA: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = scf_pkg::PATTERN_AA; // [R16]
          next_s.st = scf_pkg::ST_CAW_BACK;
        end
      end
      scf_pkg::ST_CAW_BACK: begin
        if (can_push) begin
          push      = 1'b1;
          push_data = s.pin_s2; // [R16]
          next_s.st = scf_pkg::ST_CAW_NEW;
        end
      end
      default: begin
        next_s.st = scf_pkg::ST_IDLE;
      end
    endcase

    // Two-entry answer buffer
    if (push) begin
      next_s.bufd[s.rd ^ s.count[0]] = push_data;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    case ({push, pop})
      2'b10: next_s.count = s.count + 2'd1;
      2'b01: next_s.count = s.count - 2'd1;
      default: next_s.count = s.count;
    endcase

    // Reset and presence restart the framing
    if (bus_reset) begin
      next_s.st       = scf_pkg::ST_CMD; // [R11]
      next_s.count    = 2'd0;
      next_s.rd       = 1'b0;
      next_s.car_mode = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s           <= '0;
      s.bus_s1    <= 1'b1;
      s.bus_s2    <= 1'b1;
      s.line_prev <= 1'b1;
      s.st        <= scf_pkg::ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence good_pair_s;
    s.st == scf_pkg::ST_CAW_INV && rx_valid && rx_data == ~s.first && !bus_reset;
  endsequence

  sequence bad_pair_s;
    s.st == scf_pkg::ST_CAW_INV && rx_valid && rx_data != ~s.first && !bus_reset;
  endsequence

  sequence last_sample_s;
    s.st == scf_pkg::ST_CAR && can_push && s.cnt == 6'h1f && !bus_reset;
  endsequence

  write_accept_a: assert property (good_pair_s |=> chan_write && chan_out == $past(s.first) // [R15]
    && s.st == scf_pkg::ST_CAW_AA)
    else $error("accepted write not applied");
  write_reject_a: assert property (bad_pair_s |=> !chan_write && $stable(chan_out) // [R17]
    && s.st == scf_pkg::ST_FF_LOOP)
    else $error("invalid write pair not rejected");
  write_answer_a: assert property (s.st == scf_pkg::ST_CAW_AA && can_push |-> push // [R16]
    && push_data == 8'haa)
    else $error("write answer not AAh");
  ff_fill_a: assert property (s.st == scf_pkg::ST_FF_LOOP && can_push |-> push && push_data == 8'hff) // [R12]
    else $error("fill byte not FFh");
  aa_loop_a: assert property (s.st == scf_pkg::ST_AA_LOOP && !bus_reset |=> s.st == scf_pkg::ST_AA_LOOP) // [R13]
    else $error("alternating loop left without reset");
  crc_invert_a: assert property (s.st == scf_pkg::ST_CRC_LO && can_push |-> push_data == ~s.crc[7:0]) // [R6]
    else $error("checksum low byte not inverted");
  block_end_a: assert property (last_sample_s |=> s.st == scf_pkg::ST_CRC_LO ##1 // [R14]
    s.st == scf_pkg::ST_CRC_LO || s.st == scf_pkg::ST_CRC_HI || s.st == scf_pkg::ST_CMD)
    else $error("sample block not closed after 32 bytes");
  block_restart_a: assert property (s.st == scf_pkg::ST_CRC_HI && can_push && s.car_mode && !bus_reset // [R9]
    |=> s.crc == 16'h0000 && s.cnt == 6'h00 && s.st == scf_pkg::ST_CAR)
    else $error("sample block checksum not cleared");
  hold_off_a: assert property (s.hold_cnt != '0 |=> !slot_start) // [R18]
    else $error("slot started inside hold-off");
  od_bypass_a: assert property (overdrive && s.hold_cnt == '0 && !line && s.line_prev |=> slot_start) // [R20]
    else $error("overdrive falling edge delayed");
  latch_cmd_a: assert property (s.st == scf_pkg::ST_CMD && rx_valid && rx_data == 8'h22 && !bus_reset // [R22]
    |=> latch_clear && s.st == scf_pkg::ST_AA_LOOP)
    else $error("latch clear not taken");
  restart_a: assert property (bus_reset |=> s.st == scf_pkg::ST_CMD && !tx_valid) // [R11]
    else $error("reset did not restart framing");

endmodule

/* testbench/scf_master_model.sv */
`timescale 1ns/1ps
module scf_master_model (
  input  wire logic       ref_clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            bus_reset,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready
);
  int slow;

  initial begin
    slow = 0;
    bus_reset = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // Reset, presence and selection finished
  task automatic start();
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
  endtask

  // One byte to the device; data line shows no stale value afterwards
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask

  // One byte from the device, after an optional stall
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    repeat (slow) @(posedge ref_clk);
    @(posedge ref_clk);
    tx_ready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 500);
    b = tx_data;
    tx_ready <= 1'b0;
  endtask
endmodule

/* testbench/test_slave_crc_and_command_framing.sv */
`timescale 1ns/1ps
module test_slave_crc_and_command_framing;
  logic        ref_clk;
  logic        sys_rst;
  logic        bus_in;
  logic        overdrive;
  logic        slot_start;
  logic        bus_reset;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic [7:0]  pin_in;
  logic [15:0] page_addr;
  logic [7:0]  page_rdata;
  logic [7:0]  chan_out;
  logic        chan_write;
  logic        latch_clear;
  logic [63:0] rom_code;
  int          errors;
  int          checks_done;
  int          cycles;
  int          n_slot;
  int          n_wr;
  int          n_clr;

  scf_framing i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_in(bus_in), .overdrive(overdrive),
    .slot_start(slot_start), .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .pin_in(pin_in),
    .page_addr(page_addr), .page_rdata(page_rdata), .chan_out(chan_out),
    .chan_write(chan_write), .latch_clear(latch_clear), .rom_code(rom_code)
  );

  scf_master_model i_master (
    .ref_clk(ref_clk), .tx_valid(tx_valid), .tx_data(tx_data), .bus_reset(bus_reset),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready)
  );

  // Page contents known from the address
  assign page_rdata = page_addr[7:0] ^ 8'h5c;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (slot_start === 1'b1) n_slot++;
    if (chan_write === 1'b1) n_wr++;
    if (latch_clear === 1'b1) n_clr++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  function automatic logic [15:0] upd(input logic [15:0] c, input logic [7:0] d, input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ p) : (r >> 1);
    return r;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic expect_byte(input string what, input logic [7:0] exp);
    logic [7:0] b;
    i_master.get(b);
    check(what, {8'h00, b}, {8'h00, exp});
  endtask

  task automatic expect_crc(input logic [15:0] c);
    expect_byte("crc low", ~c[7:0]);
    expect_byte("crc high", ~c[15:8]);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic test_rom();
    logic [15:0] c;
    c = 16'h0000;
    for (int k = 0; k < 7; k++) c = upd(c, rom_code[8*k +: 8], 16'h008c);
    check("rom checksum", {8'h00, rom_code[63:56]}, c);
    $display("test rom done");
  endtask

  task automatic test_glitch();
    int his[5] = '{150, 10, 150, 50, 150};
    int los[5] = '{20, 30, 5, 80, 3};
    int inc[5] = '{1, 0, 0, 1, 1};
    int n0;
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      overdrive <= (k == 4);
      n0 = n_slot;
      repeat (his[k]) @(posedge ref_clk);
      bus_in <= 1'b0;
      repeat (los[k]) @(posedge ref_clk);
      bus_in <= 1'b1;
      repeat (20) @(posedge ref_clk);
      check("slot starts", 16'(n_slot - n0), 16'(inc[k]));
    end
    overdrive <= 1'b0;
    $display("test glitch done");
  endtask

  task automatic test_page(input logic [15:0] a);
    logic [15:0] c;
    i_master.slow = 3;
    i_master.start();
    i_master.put(8'hf0);
    i_master.put(a[7:0]);
    i_master.put(a[15:8]);
    c = upd(upd(upd(16'h0000, 8'hf0, 16'ha001), a[7:0], 16'ha001), a[15:8], 16'ha001);
    if (a >= 16'h0088 && a <= 16'h008f) begin
      for (logic [15:0] x = a; x <= 16'h008f; x++) begin
        expect_byte("page data", x[7:0] ^ 8'h5c);
        c = upd(c, x[7:0] ^ 8'h5c, 16'ha001);
      end
      expect_crc(c);
    end
    repeat (2) expect_byte("fill", 8'hff);
    i_master.slow = 0;
    $display("test page read done");
  endtask

  task automatic test_write();
    logic [7:0] vals[2] = '{8'h96, 8'h01};
    logic [7:0] pins[2] = '{8'hc5, 8'h3a};
    i_master.start();
    i_master.put(8'h5a);
    foreach (vals[k]) begin
      pin_in <= pins[k];
      i_master.put(vals[k]);
      i_master.put(~vals[k]);
      expect_byte("write ack", 8'haa);
      expect_byte("pin readback", pins[k]);
      check("chan out", {8'h00, chan_out}, {8'h00, vals[k]});
    end
    i_master.put(8'h33);
    i_master.put(8'h34);
    repeat (2) expect_byte("bad pair fill", 8'hff);
    check("chan out kept", {8'h00, chan_out}, 16'h0001);
    check("write pulses", 16'(n_wr), 16'h0002);
    $display("test write done");
  endtask

  task automatic test_sample();
    logic [15:0] c;
    @(posedge ref_clk);
    pin_in <= 8'h6b;
    i_master.start();
    i_master.put(8'h11);
    c = upd(16'h0000, 8'h11, 16'ha001);
    for (int blk = 0; blk < 2; blk++) begin
      repeat (32) begin
        expect_byte("sample", 8'h6b);
        c = upd(c, 8'h6b, 16'ha001);
      end
      expect_crc(c);
      c = 16'h0000;
    end
    $display("test sample read done");
  endtask

  task automatic test_latch();
    i_master.start();
    i_master.put(8'h22);
    repeat (3) expect_byte("pattern", 8'haa);
    check("latch pulses", 16'(n_clr), 16'h0001);
    $display("test latch clear done");
  endtask

  // Mid-run reset at overdrive, then an unknown command
  task automatic test_reset();
    int n0;
    @(posedge ref_clk);
    overdrive <= 1'b1;
    sys_rst   <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("reset tx idle", {15'h0000, tx_valid}, 16'h0000);
    check("reset chan out", {8'h00, chan_out}, 16'h0000);
    n0 = n_slot;
    sys_rst <= 1'b0;
    i_master.put(8'h5a);
    repeat (10) @(posedge ref_clk);
    check("idle after reset", {15'h0000, tx_valid}, 16'h0000);
    check("no false slot", 16'(n_slot - n0), 16'h0000);
    i_master.start();
    i_master.put(8'h77);
    repeat (10) @(posedge ref_clk);
    check("unknown command quiet", {15'h0000, tx_valid}, 16'h0000);
    overdrive <= 1'b0;
    $display("test reset done");
  endtask

  initial begin
    sys_rst = 1'b1;
    bus_in = 1'b1;
    overdrive = 1'b0;
    pin_in = 8'h00;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_rom();
    test_glitch();
    test_page(16'h008e);
    test_page(16'h0090);
    test_write();
    test_sample();
    test_latch();
    test_reset();
    conclude();
  end
endmodule
